// ==== hw/pms_defs.svh ====
// Constants for the processor mode switch block
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH
`define PMS_CW_PROTECT_BIT 0
`define PMS_CW_PAGING_BIT 31
`define PMS_RESET_FETCH_ADDR 32'hffff_fff0
`define PMS_RESET_CS_BASE 32'hffff_0000
`define PMS_RESET_CS_SEL 16'hf000
`define PMS_REAL_LIMIT 32'h0000_ffff
`define PMS_REAL_CS_RIGHTS 8'h9b
`define PMS_RESET_RIGHTS 8'h93
`define PMS_TLB_FLUSH_VALUE 32'h0000_0000
`define PMS_CPL_MOST_PRIV 2'h0
`define PMS_STACK_LEVEL_MAX 2'h2
`define PMS_SEG_CODE 3'h1
`define PMS_SEG_COUNT 6
`endif

// ==== hw/pms_pkg.sv ====
// Types for the processor mode switch block
package pms_pkg;
  typedef enum logic [2:0] {
    PMS_OP_NONE,
    PMS_OP_WRITE_CW0,
    PMS_OP_FAR_BRANCH,
    PMS_OP_LOAD_TASK_REG,
    PMS_OP_WRITE_PDBR,
    PMS_OP_LOAD_SEG,
    PMS_OP_PRIV_CHANGE,
    PMS_OP_TASK_SWITCH
  } pms_op_e;

  typedef struct packed {
    pms_op_e code;
    logic [2:0] seg;
    logic [15:0] sel;
    logic [31:0] data;
    logic [7:0] rights;
  } pms_op_s;

  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] base;
    logic [31:0] limit;
    logic [7:0] rights;
    logic usable;
  } pms_seg_s;

  typedef enum {PMS_ST_REAL, PMS_ST_PROT_WAIT, PMS_ST_PROT, PMS_ST_REAL_WAIT} pms_state_e;
endpackage

// ==== hw/pms_mode_switch.sv ====
// Processor mode switch and task register start-up logic
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.svh"
module pms_mode_switch
  import pms_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic opValid,
  input wire pms_op_s opReq,
  output logic protectFlag,
  output logic pagingOnFlag,
  output logic [1:0] currentPrivilegeLevel,
  output logic [15:0] taskRegSel,
  output logic taskRegLoaded,
  output logic busyMarkPulse,
  output logic [15:0] busyMarkSel,
  output logic stackFetchPulse,
  output logic [1:0] stackFetchLevel,
  output logic taskSavePulse,
  output logic taskSaveRefused,
  output logic serializePulse,
  output logic tlbFlushPulse,
  output logic [31:0] fetchAddr,
  output logic [31:0] pageDirBase,
  output pms_seg_s codeSeg,
  output logic [`PMS_SEG_COUNT-1:0] segUsable
);

  // ************************************************************
  // Decode
  // ************************************************************
  pms_state_e state_r;
  pms_seg_s segs_r [`PMS_SEG_COUNT];
  logic cwWrite;
  logic farBranch;
  logic newProtect;
  logic newPaging;

  assign cwWrite = opValid && opReq.code == PMS_OP_WRITE_CW0;
  assign farBranch = opValid && opReq.code == PMS_OP_FAR_BRANCH;
  assign newProtect = opReq.data[`PMS_CW_PROTECT_BIT];
  // Paging needs protect in same word
  assign newPaging = opReq.data[`PMS_CW_PAGING_BIT] & newProtect;

  // ************************************************************
  // Control word zero
  // ************************************************************
  // Enter protected mode, maybe paging
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      protectFlag <= 1'b0;
      pagingOnFlag <= 1'b0;
    end else if (cwWrite) begin
      protectFlag <= newProtect;
      pagingOnFlag <= newPaging;
    end
  end

  // Mode sequencing; branch must follow the write to finish the switch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= PMS_ST_REAL;
    end else if (cwWrite) begin
      state_r <= newProtect ? PMS_ST_PROT_WAIT : PMS_ST_REAL_WAIT;
    end else if (farBranch) begin
      case (state_r)
        PMS_ST_PROT_WAIT: state_r <= PMS_ST_PROT;
        PMS_ST_REAL_WAIT: state_r <= PMS_ST_REAL;
        default: state_r <= state_r;
      endcase
    end
  end

  // Far branch serializes after the write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      serializePulse <= 1'b0;
    end else begin
      serializePulse <= farBranch && (state_r == PMS_ST_PROT_WAIT || state_r == PMS_ST_REAL_WAIT);
    end
  end

  // ************************************************************
  // Privilege level and stacks
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      currentPrivilegeLevel <= `PMS_CPL_MOST_PRIV;
      stackFetchPulse <= 1'b0;
      stackFetchLevel <= `PMS_CPL_MOST_PRIV;
    end else begin
      stackFetchPulse <= 1'b0;
      if (cwWrite && newProtect && !protectFlag) begin
        currentPrivilegeLevel <= `PMS_CPL_MOST_PRIV;
      end else if (opValid && opReq.code == PMS_OP_PRIV_CHANGE && protectFlag) begin
        currentPrivilegeLevel <= opReq.data[1:0];
        if (opReq.data[1:0] < currentPrivilegeLevel && opReq.data[1:0] <= `PMS_STACK_LEVEL_MAX) begin
          stackFetchPulse <= 1'b1;
          stackFetchLevel <= opReq.data[1:0];
        end
      end
    end
  end

  // ************************************************************
  // Task register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      taskRegSel <= 16'h0000;
      taskRegLoaded <= 1'b0;
      busyMarkPulse <= 1'b0;
      busyMarkSel <= 16'h0000;
      taskSavePulse <= 1'b0;
      taskSaveRefused <= 1'b0;
    end else begin
      busyMarkPulse <= 1'b0;
      taskSavePulse <= 1'b0;
      taskSaveRefused <= 1'b0;
      if (opValid && opReq.code == PMS_OP_LOAD_TASK_REG && protectFlag) begin
        taskRegSel <= opReq.sel;
        taskRegLoaded <= 1'b1;
        busyMarkPulse <= 1'b1;
        busyMarkSel <= opReq.sel;
      end
      if (opValid && opReq.code == PMS_OP_TASK_SWITCH) begin
        taskSavePulse <= taskRegLoaded;
        taskSaveRefused <= !taskRegLoaded;
        // Busy marking of the new task is a task switch side effect
        if (taskRegLoaded) begin
          taskRegSel <= opReq.sel;
          busyMarkPulse <= 1'b1;
          busyMarkSel <= opReq.sel;
        end
      end
    end
  end

  // ************************************************************
  // Paging base and translation flush
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pageDirBase <= 32'h0000_0000;
      tlbFlushPulse <= 1'b0;
    end else begin
      tlbFlushPulse <= 1'b0;
      if (opValid && opReq.code == PMS_OP_WRITE_PDBR) begin
        pageDirBase <= opReq.data;
        tlbFlushPulse <= opReq.data == `PMS_TLB_FLUSH_VALUE;
      end
    end
  end

  // ************************************************************
  // Segment registers
  // ************************************************************
  // Hidden parts only change on explicit loads, never on mode change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `PMS_SEG_COUNT; i++) begin
        segs_r[i] <= '{sel: 16'h0000, base: 32'h0000_0000, limit: `PMS_REAL_LIMIT,
                       rights: `PMS_RESET_RIGHTS, usable: 1'b1};
      end
      segs_r[`PMS_SEG_CODE] <= '{sel: `PMS_RESET_CS_SEL, base: `PMS_RESET_CS_BASE,
                                 limit: `PMS_REAL_LIMIT, rights: `PMS_RESET_RIGHTS, usable: 1'b1};
    end else if (farBranch) begin
      if (protectFlag) begin
        segs_r[`PMS_SEG_CODE] <= '{sel: opReq.sel, base: opReq.data, limit: segs_r[`PMS_SEG_CODE].limit,
                                   rights: opReq.rights, usable: 1'b1};
      end else begin
        segs_r[`PMS_SEG_CODE] <= '{sel: opReq.sel, base: {12'h000, opReq.sel, 4'h0},
                                   limit: `PMS_REAL_LIMIT, rights: `PMS_REAL_CS_RIGHTS, usable: 1'b1};
      end
    end else if (opValid && opReq.code == PMS_OP_LOAD_SEG && opReq.seg != `PMS_SEG_CODE
                 && opReq.seg < 3'(`PMS_SEG_COUNT)) begin
      if (protectFlag) begin
        segs_r[opReq.seg] <= '{sel: opReq.sel, base: opReq.data, limit: segs_r[opReq.seg].limit,
                               rights: opReq.rights, usable: opReq.sel[15:2] != 14'h0000};
      end else begin
        // Real load changes selector and base only; cached limit and rights persist
        segs_r[opReq.seg].sel <= opReq.sel;
        segs_r[opReq.seg].base <= {12'h000, opReq.sel, 4'h0};
      end
    end
  end

  always_comb begin
    codeSeg = segs_r[`PMS_SEG_CODE];
    for (int i = 0; i < `PMS_SEG_COUNT; i++) begin
      segUsable[i] = segs_r[i].usable;
    end
  end

  // ************************************************************
  // Instruction fetch pointer
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchAddr <= `PMS_RESET_FETCH_ADDR;
    end else if (farBranch) begin
      fetchAddr <= protectFlag ? opReq.data : {12'h000, opReq.sel, 4'h0};
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_enter_protect: assert property (cwWrite && newProtect |=> protectFlag)
    else $error("Protect flag not set by control word write");
  a_leave_protect: assert property (cwWrite && !newProtect |=> !protectFlag && !pagingOnFlag)
    else $error("Protect flag not cleared");
  a_paging_needs_pe: assert property (pagingOnFlag |-> protectFlag)
    else $error("Paging on without protected mode");
  a_cpl_zero_entry: assert property (cwWrite && newProtect && !protectFlag |=> currentPrivilegeLevel == 2'h0)
    else $error("Protected mode entered above level zero");
  a_task_load_busy: assert property (opValid && opReq.code == PMS_OP_LOAD_TASK_REG && protectFlag
    |=> busyMarkPulse && busyMarkSel == taskRegSel && !taskSavePulse)
    else $error("Task register load did not mark busy");
  a_stack_fetch_lvl: assert property (stackFetchPulse |-> stackFetchLevel <= 2'h2
    && stackFetchLevel == currentPrivilegeLevel)
    else $error("Bad stack fetch level");
  a_save_needs_tr: assert property (taskSavePulse |-> $past(taskRegLoaded))
    else $error("Task save without task register");
  a_flush_on_zero: assert property (opValid && opReq.code == PMS_OP_WRITE_PDBR
    |=> tlbFlushPulse == (pageDirBase == 32'h0000_0000))
    else $error("Translation flush mismatch");
  a_serialize_order: assert property (cwWrite ##1 farBranch |=> serializePulse)
    else $error("Far branch did not serialize");
  a_code_kept: assert property (cwWrite |=> $stable(codeSeg))
    else $error("Code segment changed by mode switch");
  a_real_cs_load: assert property (farBranch && !protectFlag
    |=> codeSeg.rights == 8'h9b && codeSeg.limit == 32'h0000_ffff)
    else $error("Real code segment not loaded");

  c_enter_paged: cover property (cwWrite && newPaging ##1 farBranch);
  c_task_load: cover property (busyMarkPulse ##[1:20] stackFetchPulse);
  c_return_real: cover property (protectFlag ##1 !protectFlag ##[1:5] serializePulse);
  c_flush: cover property (tlbFlushPulse);

endmodule
`default_nettype wire

// ==== test/pms_mode_switch_test.sv ====
// Self-checking bench for the processor mode switch block
`timescale 1ns/1ps
`default_nettype none
`include "pms_defs.svh"
module pms_mode_switch_test
  import pms_pkg::*;
;
  // ****************************************
  // Signals and design
  // ****************************************
  logic clk;
  logic rst_b;
  logic opValid;
  pms_op_s opReq;
  logic protectFlag, pagingOnFlag, taskRegLoaded, busyMarkPulse, stackFetchPulse;
  logic taskSavePulse, taskSaveRefused, serializePulse, tlbFlushPulse;
  logic [1:0] currentPrivilegeLevel, stackFetchLevel;
  logic [15:0] taskRegSel, busyMarkSel;
  logic [31:0] fetchAddr, pageDirBase;
  pms_seg_s codeSeg;
  logic [`PMS_SEG_COUNT-1:0] segUsable;
  int errTotal = 0;
  int totalChecks = 0;
  pms_mode_switch u_pms_mode_switch (.clk(clk), .rst_b(rst_b), .opValid(opValid), .opReq(opReq),
    .protectFlag(protectFlag), .pagingOnFlag(pagingOnFlag), .currentPrivilegeLevel(currentPrivilegeLevel),
    .taskRegSel(taskRegSel), .taskRegLoaded(taskRegLoaded), .busyMarkPulse(busyMarkPulse),
    .busyMarkSel(busyMarkSel), .stackFetchPulse(stackFetchPulse), .stackFetchLevel(stackFetchLevel),
    .taskSavePulse(taskSavePulse), .taskSaveRefused(taskSaveRefused), .serializePulse(serializePulse),
    .tlbFlushPulse(tlbFlushPulse), .fetchAddr(fetchAddr), .pageDirBase(pageDirBase),
    .codeSeg(codeSeg), .segUsable(segUsable));
  // ****************************************
  // Tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Inputs move on the falling edge, away from the sampling edge
  task automatic op(input pms_op_e c, input logic [2:0] s, input logic [15:0] sl, input logic [31:0] d,
      input logic [7:0] r);
    @(negedge clk);
    opValid = 1'b1;
    opReq = '{c, s, sl, d, r};
  endtask
  task automatic idle();
    @(negedge clk);
    opValid = 1'b0;
  endtask
  task automatic giveVerdict();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chkReset();
    chk("fetchAddr", fetchAddr, `PMS_RESET_FETCH_ADDR);
    chk("pagingOnFlag", {31'h0, pagingOnFlag}, 32'h0);
    chk("protectFlag", {31'h0, protectFlag}, 32'h0);
    chk("codeBase", codeSeg.base, `PMS_RESET_CS_BASE);
    chk("segUsable", {26'h0, segUsable}, 32'h3f);
  endtask
  // Watchdog so a hang still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0;
    opValid = 1'b0;
    opReq = '0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chkReset();
    // Real mode refuses task register load and privilege change
    op(PMS_OP_LOAD_TASK_REG, 3'h0, 16'h0028, 32'h0, 8'h0);
    op(PMS_OP_PRIV_CHANGE, 3'h0, 16'h0, 32'h3, 8'h0);
    chk("taskRegLoaded", {31'h0, taskRegLoaded}, 32'h0);
    op(PMS_OP_TASK_SWITCH, 3'h0, 16'h0030, 32'h0, 8'h0);
    chk("busyMarkPulse", {31'h0, busyMarkPulse}, 32'h0);
    op(PMS_OP_WRITE_CW0, 3'h0, 16'h0, 32'h8000_0000, 8'h0);
    chk("privLevel", {30'h0, currentPrivilegeLevel}, 32'h0);
    chk("taskSaveRefused", {31'h0, taskSaveRefused}, 32'h1);
    chk("taskSavePulse", {31'h0, taskSavePulse}, 32'h0);
    idle();
    chk("pagingOnFlag", {31'h0, pagingOnFlag}, 32'h0);
    chk("protectFlag", {31'h0, protectFlag}, 32'h0);
    // Pending wait closes on the first branch; a second branch does not serialize
    op(PMS_OP_FAR_BRANCH, 3'h0, 16'hf000, 32'h0, 8'h0);
    op(PMS_OP_FAR_BRANCH, 3'h0, 16'hf000, 32'h0, 8'h0);
    chk("serializePulse", {31'h0, serializePulse}, 32'h1);
    idle();
    chk("serializePulse", {31'h0, serializePulse}, 32'h0);
    chk("fetchAddr", fetchAddr, 32'h000f_0000);
    // No interrupt stimulus during the switch
    // Control word, branch, task register, segments
    op(PMS_OP_WRITE_CW0, 3'h0, 16'h0, 32'h8000_0001, 8'h0);
    op(PMS_OP_FAR_BRANCH, 3'h0, 16'h0008, 32'h0000_1000, 8'h9a);
    chk("protectFlag", {31'h0, protectFlag}, 32'h1);
    chk("pagingOnFlag", {31'h0, pagingOnFlag}, 32'h1);
    chk("privLevel", {30'h0, currentPrivilegeLevel}, 32'h0);
    chk("codeBase", codeSeg.base, 32'h000f_0000);
    op(PMS_OP_LOAD_TASK_REG, 3'h0, 16'h0028, 32'h0, 8'h0);
    chk("serializePulse", {31'h0, serializePulse}, 32'h1);
    chk("fetchAddr", fetchAddr, 32'h0000_1000);
    chk("codeSel", {16'h0, codeSeg.sel}, 32'h0008);
    idle();
    chk("taskRegSel", {16'h0, taskRegSel}, 32'h0028);
    chk("taskRegLoaded", {31'h0, taskRegLoaded}, 32'h1);
    chk("busyMarkPulse", {31'h0, busyMarkPulse}, 32'h1);
    chk("busyMarkSel", {16'h0, busyMarkSel}, 32'h0028);
    chk("taskSavePulse", {31'h0, taskSavePulse}, 32'h0);
    // Inner stacks for levels 2, 1 and 0 come from the task segment
    for (int lv = 2; lv >= 0; lv--) begin
      op(PMS_OP_PRIV_CHANGE, 3'h0, 16'h0, 32'h3, 8'h0);
      idle();
      chk("stackFetchPulse", {31'h0, stackFetchPulse}, 32'h0);
      op(PMS_OP_PRIV_CHANGE, 3'h0, 16'h0, lv, 8'h0);
      idle();
      chk("stackFetchPulse", {31'h0, stackFetchPulse}, 32'h1);
      chk("stackFetchLevel", {30'h0, stackFetchLevel}, lv);
    end
    op(PMS_OP_TASK_SWITCH, 3'h0, 16'h0030, 32'h0, 8'h0);
    op(PMS_OP_WRITE_PDBR, 3'h0, 16'h0, 32'h0000_3000, 8'h0);
    chk("taskSavePulse", {31'h0, taskSavePulse}, 32'h1);
    chk("taskSaveRefused", {31'h0, taskSaveRefused}, 32'h0);
    op(PMS_OP_WRITE_PDBR, 3'h0, 16'h0, `PMS_TLB_FLUSH_VALUE, 8'h0);
    chk("tlbFlushPulse", {31'h0, tlbFlushPulse}, 32'h0);
    chk("pageDirBase", pageDirBase, 32'h0000_3000);
    // Null selector in segment 3, a real one in segment 2
    op(PMS_OP_LOAD_SEG, 3'h3, 16'h0000, 32'h0, 8'h93);
    chk("tlbFlushPulse", {31'h0, tlbFlushPulse}, 32'h1);
    op(PMS_OP_LOAD_SEG, 3'h2, 16'h0010, 32'h0, 8'h93);
    op(PMS_OP_WRITE_CW0, 3'h0, 16'h0, 32'h0, 8'h0);
    op(PMS_OP_FAR_BRANCH, 3'h0, 16'h1234, 32'h0, 8'h0);
    chk("protectFlag", {31'h0, protectFlag}, 32'h0);
    chk("pagingOnFlag", {31'h0, pagingOnFlag}, 32'h0);
    idle();
    chk("serializePulse", {31'h0, serializePulse}, 32'h1);
    chk("fetchAddr", fetchAddr, 32'h0001_2340);
    chk("codeBase", codeSeg.base, 32'h0001_2340);
    chk("codeLimit", codeSeg.limit, `PMS_REAL_LIMIT);
    chk("codeRights", {24'h0, codeSeg.rights}, {24'h0, `PMS_REAL_CS_RIGHTS});
    chk("segUsable", {26'h0, segUsable}, 32'h37);
    // Reset in mid-run restores the start state at once
    @(negedge clk);
    rst_b = 1'b0;
    #1;
    chkReset();
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chkReset();
    giveVerdict();
  end
endmodule
`default_nettype wire
